// ### design/indexed_port_watchdog_timer.sv
// Purpose: Watchdog timer behind an index/data host port pair
// Assumes: Host port strobes are synchronous to clk_i; activity inputs are not
// Notes: Notes on behaviour follow
module indexed_port_watchdog_timer
    import wdt_pkg::*;
#(
    parameter longint SEC_CYCLES = wdt_pkg::SEC_CYCLES_DEF
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Host port access
    input wire logic [7:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    // Activity sources, asynchronous
    input wire logic mouse_act_i,
    input wire logic kbd_act_i,
    // Timeout signal
    output logic timeout_o
);
    import wdt_pkg::*;

    // ************************************************
    // Declarations
    // ************************************************
    cfg_state_e state, next_state;
    logic [7:0] index, next_index;
    logic [7:0] bank, next_bank;
    logic active, next_active;
    logic unit_min, next_unit_min;
    logic [7:0] reload, next_reload;
    logic [7:0] cnt, next_cnt;
    logic mouse_en, next_mouse_en;
    logic kbd_en, next_kbd_en;
    logic timed_out, next_timed_out;
    logic [7:0] rdata, next_rdata;
    logic [31:0] sec_cnt, next_sec_cnt;
    logic [5:0] min_cnt, next_min_cnt;
    logic [1:0] mouse_sync, kbd_sync;
    logic mouse_last, kbd_last;
    logic addr_wr, data_wr, data_rd;
    logic sec_tick, min_tick, unit_tick;
    logic mouse_pulse, kbd_pulse, act_reload;
    logic count_wr, force_wr;

    // Selected bank register hit while access is open
    function automatic logic reg_hit(input cfg_state_e st, input logic [7:0] bk,
                                     input logic [7:0] idx, input logic [7:0] want);
        reg_hit = (st == CFG_OPEN) && (bk == BANK_WDT) && (idx == want);
    endfunction

    // ************************************************
    // Port decode
    // ************************************************
    // Address and data port strobes
    assign addr_wr = io_wr_i && (io_addr_i == ADDR_PORT);
    assign data_wr = io_wr_i && (io_addr_i == DATA_PORT) && (state == CFG_OPEN);
    assign data_rd = io_rd_i && (io_addr_i == DATA_PORT);
    assign count_wr = data_wr && reg_hit(state, bank, index, IDX_COUNT);
    assign force_wr = data_wr && reg_hit(state, bank, index, IDX_CTRL) && io_wdata_i[FORCE_BIT];

    // ************************************************
    // Activity synchronisers
    // ************************************************
    // Two flops before use; edge detect sits on the second stage only
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            mouse_sync <= 2'h0;
            kbd_sync <= 2'h0;
            mouse_last <= 1'b0;
            kbd_last <= 1'b0;
        end
        else
        begin
            mouse_sync <= {mouse_sync[0], mouse_act_i};
            kbd_sync <= {kbd_sync[0], kbd_act_i};
            mouse_last <= mouse_sync[1];
            kbd_last <= kbd_sync[1];
        end
    end

    // Rising edges count as one activity event each
    assign mouse_pulse = mouse_sync[1] && !mouse_last;
    assign kbd_pulse = kbd_sync[1] && !kbd_last;
    assign act_reload = (mouse_pulse && mouse_en) || (kbd_pulse && kbd_en);

    // ************************************************
    // Configuration access and registers
    // ************************************************
    // Unlock sequence, index capture and register writes
    always_comb
    begin
        next_state = state;
        next_index = index;
        next_bank = bank;
        next_active = active;
        next_unit_min = unit_min;
        next_reload = reload;
        next_mouse_en = mouse_en;
        next_kbd_en = kbd_en;
        if (addr_wr)
        begin
            unique case (state)
                CFG_LOCKED: next_state = (io_wdata_i == KEY_UNLOCK) ? CFG_KEY1 : CFG_LOCKED;
                CFG_KEY1: next_state = (io_wdata_i == KEY_UNLOCK) ? CFG_OPEN : CFG_LOCKED;
                CFG_OPEN:
                begin
                    if (io_wdata_i == KEY_LOCK)
                        next_state = CFG_LOCKED;
                    else
                        next_index = io_wdata_i;
                end
                default: next_state = CFG_LOCKED;
            endcase
        end
        if (data_wr)
        begin
            if (index == IDX_BANK)
                next_bank = io_wdata_i;
            if (reg_hit(state, bank, index, IDX_ACTIVATE))
                next_active = (io_wdata_i == ACTIVATE_ON);
            if (reg_hit(state, bank, index, IDX_UNIT))
                next_unit_min = io_wdata_i[UNIT_BIT];
            if (count_wr)
                next_reload = io_wdata_i;
            if (reg_hit(state, bank, index, IDX_CTRL))
            begin
                next_mouse_en = io_wdata_i[MOUSE_BIT];
                next_kbd_en = io_wdata_i[KBD_BIT];
            end
        end
    end

    // Configuration registers; everything disabled after reset
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            state <= CFG_LOCKED;
            index <= BYTE_ZERO;
            bank <= BANK_RESET;
            active <= 1'b0;
            unit_min <= 1'b0;
            reload <= COUNT_RESET;
            mouse_en <= 1'b0;
            kbd_en <= 1'b0;
        end
        else
        begin
            state <= next_state;
            index <= next_index;
            bank <= next_bank;
            active <= next_active;
            unit_min <= next_unit_min;
            reload <= next_reload;
            mouse_en <= next_mouse_en;
            kbd_en <= next_kbd_en;
        end
    end

    // ************************************************
    // Tick generation
    // ************************************************
    // Prescalers restart on a count write so the first period is whole
    assign sec_tick = active && (sec_cnt == 32'(SEC_CYCLES - 1));
    assign min_tick = sec_tick && (min_cnt == SEC_PER_MIN - 6'h01);
    assign unit_tick = unit_min ? min_tick : sec_tick;
    always_comb
    begin
        next_sec_cnt = sec_cnt;
        next_min_cnt = min_cnt;
        if (count_wr || !active)
        begin
            next_sec_cnt = 32'h0;
            next_min_cnt = 6'h00;
        end
        else if (sec_tick)
        begin
            next_sec_cnt = 32'h0;
            next_min_cnt = min_tick ? 6'h00 : min_cnt + 6'h01;
        end
        else
            next_sec_cnt = sec_cnt + 32'h1;
    end
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            sec_cnt <= 32'h0;
            min_cnt <= 6'h00;
        end
        else
        begin
            sec_cnt <= next_sec_cnt;
            min_cnt <= next_min_cnt;
        end
    end

    // ************************************************
    // Countdown and timeout
    // ************************************************
    // Reload beats a tick; expiry or a forced timeout beats the clear
    always_comb
    begin
        next_cnt = cnt;
        next_timed_out = timed_out;
        if (count_wr)
        begin
            next_cnt = io_wdata_i;
            next_timed_out = 1'b0;
        end
        else if (act_reload && active)
            next_cnt = reload;
        else if (unit_tick && (cnt != COUNT_RESET))
            next_cnt = cnt - 8'h01;
        if (unit_tick && (cnt == 8'h01) && !(act_reload && active))
            next_timed_out = 1'b1;
        if (force_wr && active)
            next_timed_out = 1'b1;
    end
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            cnt <= COUNT_RESET;
            timed_out <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            timed_out <= next_timed_out;
        end
    end
    assign timeout_o = timed_out;

    // ************************************************
    // Read path
    // ************************************************
    // Force bit always reads zero since it clears itself
    always_comb
    begin
        next_rdata = rdata;
        if (io_rd_i && (io_addr_i == ADDR_PORT))
            next_rdata = index;
        else if (data_rd)
        begin
            next_rdata = BYTE_ZERO;
            if (state == CFG_OPEN && index == IDX_BANK)
                next_rdata = bank;
            else if (reg_hit(state, bank, index, IDX_ACTIVATE))
                next_rdata[ACTIVE_BIT] = active;
            else if (reg_hit(state, bank, index, IDX_UNIT))
                next_rdata[UNIT_BIT] = unit_min;
            else if (reg_hit(state, bank, index, IDX_COUNT))
                next_rdata = cnt;
            else if (reg_hit(state, bank, index, IDX_CTRL))
            begin
                next_rdata[MOUSE_BIT] = mouse_en;
                next_rdata[KBD_BIT] = kbd_en;
                next_rdata[STATUS_BIT] = timed_out;
            end
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
            rdata <= BYTE_ZERO;
        else
            rdata <= next_rdata;
    end
    assign io_rdata_o = rdata;

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    a_unlock_two_keys: assert property ((state == CFG_KEY1) && addr_wr && (io_wdata_i == KEY_UNLOCK)
        |=> state == CFG_OPEN)
        else $error("two unlock keys did not open access");
    a_lock_key: assert property ((state == CFG_OPEN) && addr_wr && (io_wdata_i == KEY_LOCK)
        |=> state == CFG_LOCKED)
        else $error("lock key did not close access");
    a_locked_ignore: assert property ((state != CFG_OPEN) && io_wr_i && (io_addr_i == DATA_PORT)
        |=> $stable(bank) && $stable(reload) && $stable(active) && $stable(mouse_en))
        else $error("locked data write changed a setting");
    a_bank_select: assert property (data_wr && (index == IDX_BANK)
        |=> bank == $past(io_wdata_i))
        else $error("bank select not stored");
    a_stays_disabled: assert property (!active && !timed_out && !$past(active) |=> !timed_out)
        else $error("timeout while watchdog disabled");
    a_unit_store: assert property (data_wr && reg_hit(state, bank, index, IDX_UNIT)
        |=> unit_min == $past(io_wdata_i[UNIT_BIT]))
        else $error("unit bit not stored");
    a_zero_stops: assert property ((cnt == COUNT_RESET) && !count_wr && !act_reload
        |=> cnt == COUNT_RESET)
        else $error("zero count did not stay stopped");
    a_expiry_out: assert property (!count_wr && !act_reload && unit_tick && (cnt == 8'h01)
        |=> timed_out && timeout_o && (cnt == COUNT_RESET))
        else $error("expiry did not raise timeout");
    a_count_restart: assert property (count_wr |=> (cnt == $past(io_wdata_i)) && (sec_cnt == 32'h0))
        else $error("count write did not restart countdown");
    a_mouse_reload: assert property (!count_wr && active && mouse_pulse && mouse_en
        |=> cnt == $past(reload))
        else $error("mouse activity did not reload");
    a_kbd_reload: assert property (!count_wr && active && kbd_pulse && kbd_en
        |=> cnt == $past(reload))
        else $error("keyboard activity did not reload");
    a_force_now: assert property (force_wr && active |=> timeout_o)
        else $error("forced timeout not raised");
    a_status_read: assert property (data_rd && reg_hit(state, bank, index, IDX_CTRL)
        |=> (io_rdata_o[STATUS_BIT] == $past(timed_out)) && !io_rdata_o[FORCE_BIT])
        else $error("status read mismatch");
    a_tick_step: assert property (!count_wr && !act_reload && (cnt != COUNT_RESET)
        |=> cnt == ($past(unit_tick) ? $past(cnt) - 8'h01 : $past(cnt)))
        else $error("count did not step once per tick");
endmodule

// ### design/wdt_pkg.sv
// Purpose: Shared constants for the indexed port watchdog timer
// Assumes: 200 MHz core clock, 8-bit host port interface
// Notes: Port addresses, keys, indexes and field positions live here
package wdt_pkg;

    // ************************************************
    // Host ports and keys
    // ************************************************
    localparam logic [7:0] ADDR_PORT = 8'h2E;
    localparam logic [7:0] DATA_PORT = 8'h2F;
    localparam logic [7:0] KEY_UNLOCK = 8'h87;
    localparam logic [7:0] KEY_LOCK = 8'hAA;

    // ************************************************
    // Register indexes and values
    // ************************************************
    localparam logic [7:0] IDX_BANK = 8'h07;
    localparam logic [7:0] BANK_WDT = 8'h08;
    localparam logic [7:0] IDX_ACTIVATE = 8'h30;
    localparam logic [7:0] ACTIVATE_ON = 8'h01;
    localparam logic [7:0] IDX_UNIT = 8'hF5;
    localparam logic [7:0] IDX_COUNT = 8'hF6;
    localparam logic [7:0] IDX_CTRL = 8'hF7;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BANK_RESET = 8'h00;

    // ************************************************
    // Field positions
    // ************************************************
    localparam int UNIT_BIT = 3;
    localparam int MOUSE_BIT = 7;
    localparam int KBD_BIT = 6;
    localparam int FORCE_BIT = 5;
    localparam int STATUS_BIT = 4;
    localparam int ACTIVE_BIT = 0;

    // ************************************************
    // Timing
    // ************************************************
    localparam longint CLK_HZ = 200000000;
    localparam longint TICK_TIME_S = 1;
    localparam longint SEC_CYCLES_DEF = CLK_HZ * TICK_TIME_S;
    localparam logic [5:0] SEC_PER_MIN = 6'h3C;

    // Configuration access states
    typedef enum logic [1:0]
    {
        CFG_LOCKED = 2'b00,
        CFG_KEY1 = 2'b01,
        CFG_OPEN = 2'b10
    } cfg_state_e;

endpackage

// ### test/indexed_port_watchdog_timer_bench.sv
// Purpose: Self-checking bench for the indexed port watchdog timer
// Assumes: SEC_CYCLES cut to 40 so a minute count fits in the run
// Notes: Host strobes last one cycle with an idle cycle between accesses
module indexed_port_watchdog_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import wdt_pkg::*;

    // ************
    // Stimulus and instance
    // ************
    localparam longint SEC = 40;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] io_addr_i = 8'h00;
    logic io_wr_i = 1'b0;
    logic io_rd_i = 1'b0;
    logic [7:0] io_wdata_i = 8'h00;
    logic [7:0] io_rdata_o;
    logic mouse_act_i = 1'b0;
    logic kbd_act_i = 1'b0;
    logic timeout_o;
    int n_mismatch = 0;
    int cmp_count = 0;
    logic [7:0] rv;

    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;

    indexed_port_watchdog_timer #(.SEC_CYCLES(SEC)) indexed_port_watchdog_timer_i (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .io_addr_i(io_addr_i),
        .io_wr_i(io_wr_i),
        .io_rd_i(io_rd_i),
        .io_wdata_i(io_wdata_i),
        .io_rdata_o(io_rdata_o),
        .mouse_act_i(mouse_act_i),
        .kbd_act_i(kbd_act_i),
        .timeout_o(timeout_o)
    );

    // ************
    // Shared tasks
    // ************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // One write strobe; lowered at the taking edge so the next call waits an edge
    task automatic port_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        io_addr_i <= a;
        io_wdata_i <= d;
        io_wr_i <= 1'b1;
        @(posedge clk_i);
        io_wr_i <= 1'b0;
    endtask

    // Read data is registered, so it is taken one edge after the strobe
    task automatic port_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        io_addr_i <= a;
        io_rd_i <= 1'b1;
        @(posedge clk_i);
        io_rd_i <= 1'b0;
        @(posedge clk_i);
        d = io_rdata_o;
    endtask

    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] v);
        port_wr(ADDR_PORT, idx);
        port_wr(DATA_PORT, v);
    endtask

    task automatic reg_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        port_wr(ADDR_PORT, idx);
        port_rd(DATA_PORT, rv);
        check(what, rv, exp);
    endtask

    task automatic unlock();
        port_wr(ADDR_PORT, KEY_UNLOCK);
        port_wr(ADDR_PORT, KEY_UNLOCK);
    endtask

    // Bounded wait for expiry; running out ends the run as a failure
    task automatic wait_timeout(input int n);
        int i;
        for (i = 0; i < n; i++)
        begin
            @(posedge clk_i);
            if (timeout_o === 1'b1)
                return;
        end
        n_mismatch++;
        $display("MISMATCH timeout_o expected 1 seen %b", timeout_o);
        end_sim();
    endtask

    // Three-cycle activity pulse, long enough for the input synchronisers
    task automatic pulse(input logic m);
        @(posedge clk_i);
        mouse_act_i <= m;
        kbd_act_i <= ~m;
        repeat (3) @(posedge clk_i);
        mouse_act_i <= 1'b0;
        kbd_act_i <= 1'b0;
    endtask

    // ************
    // Scenarios
    // ************
    // A stray address write between the keys leaves the space closed
    task automatic t_unlock_order();
        port_wr(ADDR_PORT, KEY_UNLOCK);
        port_wr(ADDR_PORT, 8'h55);
        port_wr(ADDR_PORT, KEY_UNLOCK);
        reg_wr(IDX_BANK, BANK_WDT);
        unlock();
        reg_chk("bank after broken key", IDX_BANK, 8'h00);
    endtask

    // Count writes are dropped until the watchdog bank is selected
    task automatic t_bank();
        reg_wr(IDX_COUNT, 8'h05);
        reg_wr(IDX_BANK, BANK_WDT);
        reg_chk("count before bank", IDX_COUNT, 8'h00);
        reg_chk("bank", IDX_BANK, BANK_WDT);
        port_rd(ADDR_PORT, rv);
        check("index readback", rv, IDX_BANK);
    endtask

    task automatic t_reset_values();
        reg_chk("activate reset", IDX_ACTIVATE, 8'h00);
        reg_chk("unit reset", IDX_UNIT, 8'h00);
        reg_chk("count reset", IDX_COUNT, 8'h00);
        reg_chk("control reset", IDX_CTRL, 8'h00);
        check("timeout reset", {7'h00, timeout_o}, 8'h00);
    endtask

    // Neither countdown nor force acts before activation; only value one activates
    task automatic t_inactive();
        reg_wr(IDX_ACTIVATE, 8'h02);
        reg_chk("activate other value", IDX_ACTIVATE, 8'h00);
        reg_wr(IDX_COUNT, 8'h01);
        reg_wr(IDX_CTRL, 8'h20);
        repeat (3 * SEC) @(posedge clk_i);
        check("timeout inactive", {7'h00, timeout_o}, 8'h00);
    endtask

    task automatic t_countdown();
        reg_wr(IDX_ACTIVATE, ACTIVATE_ON);
        reg_wr(IDX_COUNT, 8'h03);
        repeat (100) @(posedge clk_i);
        reg_chk("count after two ticks", IDX_COUNT, 8'h01);
        check("timeout early", {7'h00, timeout_o}, 8'h00);
        wait_timeout(40);
        reg_chk("status timed out", IDX_CTRL, 8'h10);
    endtask

    // A rewrite before expiry restarts the count and clears the status
    task automatic t_reload();
        reg_wr(IDX_COUNT, 8'h03);
        @(posedge clk_i);
        check("timeout cleared", {7'h00, timeout_o}, 8'h00);
        repeat (100) @(posedge clk_i);
        reg_wr(IDX_COUNT, 8'h03);
        repeat (100) @(posedge clk_i);
        check("timeout after reload", {7'h00, timeout_o}, 8'h00);
        reg_chk("count after reload", IDX_COUNT, 8'h01);
    endtask

    task automatic t_force();
        reg_wr(IDX_COUNT, 8'h00);
        reg_wr(IDX_CTRL, 8'h20);
        @(posedge clk_i);
        check("forced timeout", {7'h00, timeout_o}, 8'h01);
        reg_chk("force self clears", IDX_CTRL, 8'h10);
    endtask

    // Activity reloads only when its enable bit is set
    task automatic t_activity(input logic [7:0] ctrl, input logic m, input logic [7:0] exp);
        reg_wr(IDX_CTRL, ctrl);
        reg_wr(IDX_COUNT, 8'h02);
        repeat (50) @(posedge clk_i);
        pulse(m);
        repeat (5) @(posedge clk_i);
        reg_chk("count after activity", IDX_COUNT, exp);
    endtask

    // A count of two minutes outlives many second ticks
    task automatic t_minutes();
        reg_wr(IDX_CTRL, 8'h00);
        reg_wr(IDX_UNIT, 8'h08);
        reg_chk("unit minutes", IDX_UNIT, 8'h08);
        reg_wr(IDX_COUNT, 8'h02);
        repeat (3 * SEC) @(posedge clk_i);
        check("timeout minutes early", {7'h00, timeout_o}, 8'h00);
        wait_timeout(121 * SEC + 20);
    endtask

    // After the lock key, data writes leave settings untouched
    task automatic t_lock();
        reg_wr(IDX_COUNT, 8'h00);
        port_wr(ADDR_PORT, KEY_LOCK);
        reg_wr(IDX_UNIT, 8'h00);
        unlock();
        reg_chk("unit held while locked", IDX_UNIT, 8'h08);
    endtask

    initial
    begin
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_unlock_order();
        t_bank();
        t_reset_values();
        t_inactive();
        t_countdown();
        t_reload();
        t_force();
        t_activity(8'h80, 1'b1, 8'h02);
        t_activity(8'h40, 1'b0, 8'h02);
        t_activity(8'h40, 1'b1, 8'h01);
        t_activity(8'h80, 1'b0, 8'h01);
        t_minutes();
        t_lock();
        end_sim();
    end
endmodule
